// ==== design/bct_pkg.sv ====
// Shared constants for the step-down converter control register bank.
// Assumes a single 125 MHz clock and a byte-wide host register port.
package bct_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_MODE_LIMIT_FIRST = 8'h2C;
   localparam logic [7:0] ADDR_MODE_LIMIT_SECOND = 8'h2D;
   localparam logic [7:0] ADDR_CORE_VOLTAGE = 8'h2E;
   localparam logic [7:0] RESET_MODE_LIMIT_FIRST = 8'h00;
   localparam logic [7:0] RESET_MODE_LIMIT_SECOND = 8'h00;
   localparam logic [7:0] RESET_CORE_VOLTAGE = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int OP_SELECT_LO_POS = 0;
   localparam int CURRENT_CAP_LO_POS = 2;
   localparam int OP_SELECT_HI_POS = 4;
   localparam int CURRENT_CAP_HI_POS = 6;
   localparam int FIELD2_W = 2;
   localparam int VOLTAGE_CODE_POS = 0;
   localparam int VOLTAGE_CODE_W = 6;
   localparam int TURN_ON_POS = 6;
   localparam int PRESET_SELECT_POS = 7;

   // ----------------------------------------------------------------
   // Operating modes
   // ----------------------------------------------------------------
   localparam logic [1:0] OP_SLEEP = 2'h0;
   localparam logic [1:0] OP_AUTO = 2'h1;
   localparam logic [1:0] OP_SYNC = 2'h2;
   localparam logic [1:0] OP_AUTO_FORCE_SYNC = 2'h3;

   // ----------------------------------------------------------------
   // Voltage ramp: level counted in 6.25 mV quarter steps of a code
   // ----------------------------------------------------------------
   localparam int LEVEL_W = 8;
   localparam int QUARTERS_PER_CODE = 4;
   localparam logic [7:0] FLOOR_LEVEL = 8'h24; // Code 9, 0.725 V
   localparam int STEP_TIME_NS = 1000;          // One 6.25 mV step per us
   localparam int CLK_PERIOD_NS = 8;
   localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== design/bct_ramp_if.sv ====
// Carrier between the register bank and the voltage ramp engine.
// Assumes both ends share clk; start is a one-cycle pulse.
`timescale 1ns/1ns
interface bct_ramp_if;
   logic start;
   logic [7:0] target;
   logic [7:0] level;
   logic slewing;

   modport ctrl (output start, output target, input level, input slewing);
   modport engine (input start, input target, output level, output slewing);
endinterface

// ==== design/bct_ramp_engine.sv ====
// Slew-limited voltage ramp for the core converter.
// Assumes start is a single-cycle pulse from the register bank.
`timescale 1ns/1ns
module bct_ramp_engine #(
   parameter int STEP_CYCLES = bct_pkg::STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   bct_ramp_if.engine ramp
);

   typedef enum logic [1:0] {
      RAMP_IDLE = 2'b01,
      RAMP_SLEW = 2'b10
   } bct_ramp_e;

   localparam logic [15:0] LAST_TICK = 16'(STEP_CYCLES - 1);

   bct_ramp_e state;
   logic [7:0] goal;
   logic [7:0] level;
   logic [15:0] tick;

   // The tick counter is 16 bits wide, so longer step times cannot be served
   if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) begin : g_bad_step
      $error("bct_ramp_engine: STEP_CYCLES out of range");
   end

   // ----------------------------------------------------------------
   // Ramp sequencer
   // ----------------------------------------------------------------
   // A new start retargets mid-ramp, but one arriving on the cycle the ramp returns to idle is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= RAMP_IDLE;
         goal <= 8'h00;
         level <= 8'h00;
         tick <= 16'h0000;
      end else begin
         if (ramp.start) begin
            goal <= ramp.target;
         end
         unique case (state)
            RAMP_IDLE: begin
               tick <= 16'h0000;
               if (ramp.start && ramp.target != level) begin
                  state <= RAMP_SLEW;
               end
            end
            RAMP_SLEW: begin
               if (tick != LAST_TICK) begin
                  tick <= tick + 16'h0001;
               end else begin
                  tick <= 16'h0000;
                  if (level < goal) begin
                     level <= level + 8'h01;
                  end else if (level > goal) begin
                     // Below the floor the slew control hands over to sleep
                     if (goal < bct_pkg::FLOOR_LEVEL && level <= bct_pkg::FLOOR_LEVEL) begin
                        level <= goal;
                     end else begin
                        level <= level - 8'h01;
                     end
                  end else begin
                     state <= RAMP_IDLE;
                  end
               end
            end
         endcase
      end
   end

   assign ramp.level = level;
   assign ramp.slewing = (state == RAMP_SLEW);

endmodule

// ==== design/bct_buck_regs.sv ====
// Control register bank for four step-down converters, with the core
// converter's voltage, enable and preset handling.
// Assumes the control interface delivers byte accesses synchronous to clk.
//
// Notes on behaviour
// - Core mode in first register bits 1:0: sleep, auto, sync, auto-forcing-sync.
// - Core current cap bits 3:2: 1600, 2000, 2400, 3000 mA.
// - Processor mode in first register bits 5:4, same four-code encoding.
// - Processor current cap bits 7:6: 800, 1000, 1200, 1500 mA.
// - Memory mode in second register bits 1:0, same encoding.
// - Memory current cap second register bits 3:2: 800 to 1500 mA.
// - Peripheral mode in second register bits 5:4; code 10 holds synchronous.
// - Peripheral current cap bits 7:6: 800 to 1500 mA.
// - Core voltage code bits 5:0, 0.500 V plus 25 mV per code.
// - Core voltage register bit 6 turns the core converter on or off.
// - Bit 7 chooses ramp-on-trigger or hold-as-preset for a new code.
// - All fields are host readable and writable; software sets what it needs.
// - Slewing moves the output 6.25 mV per microsecond; it jumps only when dropping from 0.725 V or below to a lower target.
// - Dropping from 0.725 V or below, the level jumps straight to the target and sleep operation takes over.
// - Reset power state switches off every converter regardless of enables.
// - With preset bit high, triggers are always ignored; only the sequencer slot applies.
`timescale 1ns/1ns
module bct_buck_regs #(
   parameter logic [7:0] RESET_FIRST = bct_pkg::RESET_MODE_LIMIT_FIRST,
   parameter logic [7:0] RESET_SECOND = bct_pkg::RESET_MODE_LIMIT_SECOND,
   parameter logic [7:0] RESET_CORE = bct_pkg::RESET_CORE_VOLTAGE,
   parameter int STEP_CYCLES = bct_pkg::STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic regRead,
   output logic [7:0] regReadData,
   output logic regReadValid,
   input wire logic coreRampTrigger,
   input wire logic coreSequencerSlot,
   input wire logic resetPowerState,
   output logic [1:0] coreOpSelect,
   output logic [1:0] coreCurrentCap,
   output logic [1:0] processorOpSelect,
   output logic [1:0] processorCurrentCap,
   output logic [1:0] memoryOpSelect,
   output logic [1:0] memoryCurrentCap,
   output logic [1:0] peripheralOpSelect,
   output logic [1:0] peripheralCurrentCap,
   output logic [7:0] coreVoltageLevel,
   output logic coreSlewing,
   output logic coreStepDownOn,
   output logic allStepDownHalt
);

   bct_ramp_if ramp ();

   logic [7:0] modeLimitFirst;
   logic [7:0] modeLimitSecond;
   logic [7:0] coreVoltage;
   logic coreTurnOnApplied;
   logic rampStart;
   logic [7:0] rampTarget;
   logic [5:0] coreVoltageCode;
   logic corePresetSelect;
   logic coreTurnOn;
   logic coreApplyNow;

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The ramp engine counts step time in a 16-bit tick counter
   if (STEP_CYCLES < 1 || STEP_CYCLES > 65536) begin : g_bad_step
      $error("bct_buck_regs: STEP_CYCLES must lie in 1 to 65536");
   end
   // Overlapping offsets would let one write land in two registers
   if (bct_pkg::ADDR_MODE_LIMIT_FIRST == bct_pkg::ADDR_MODE_LIMIT_SECOND
      || bct_pkg::ADDR_MODE_LIMIT_FIRST == bct_pkg::ADDR_CORE_VOLTAGE
      || bct_pkg::ADDR_MODE_LIMIT_SECOND == bct_pkg::ADDR_CORE_VOLTAGE) begin : g_bad_map
      $error("bct_buck_regs: register offsets overlap");
   end
   // Field slices must stay inside the byte-wide registers
   if (bct_pkg::CURRENT_CAP_HI_POS + bct_pkg::FIELD2_W > 8
      || bct_pkg::VOLTAGE_CODE_POS + bct_pkg::VOLTAGE_CODE_W > 8) begin : g_bad_field
      $error("bct_buck_regs: a field runs past bit 7");
   end

   assign coreVoltageCode = coreVoltage[bct_pkg::VOLTAGE_CODE_POS +: bct_pkg::VOLTAGE_CODE_W];
   assign coreTurnOn = coreVoltage[bct_pkg::TURN_ON_POS];
   assign corePresetSelect = coreVoltage[bct_pkg::PRESET_SELECT_POS];
   // The preset bit picks which command applies the core settings
   assign coreApplyNow = corePresetSelect ? coreSequencerSlot : coreRampTrigger;

   // ----------------------------------------------------------------
   // Host register writes
   // ----------------------------------------------------------------
   // Every field is plain read/write; hardware never alters them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeLimitFirst <= RESET_FIRST;
         modeLimitSecond <= RESET_SECOND;
         coreVoltage <= RESET_CORE;
      end else if (regWrite) begin
         if (regAddr == bct_pkg::ADDR_MODE_LIMIT_FIRST) begin
            modeLimitFirst <= regWriteData;
         end
         if (regAddr == bct_pkg::ADDR_MODE_LIMIT_SECOND) begin
            modeLimitSecond <= regWriteData;
         end
         if (regAddr == bct_pkg::ADDR_CORE_VOLTAGE) begin
            coreVoltage <= regWriteData;
         end
      end
   end

   // ----------------------------------------------------------------
   // Host register reads
   // ----------------------------------------------------------------
   // Registered read data, one cycle after the strobe; unmapped reads zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         regReadData <= bct_pkg::READ_UNMAPPED;
         regReadValid <= 1'b0;
      end else begin
         regReadValid <= regRead;
         if (regRead) begin
            unique case (regAddr)
               bct_pkg::ADDR_MODE_LIMIT_FIRST: regReadData <= modeLimitFirst;
               bct_pkg::ADDR_MODE_LIMIT_SECOND: regReadData <= modeLimitSecond;
               bct_pkg::ADDR_CORE_VOLTAGE: regReadData <= coreVoltage;
               default: regReadData <= bct_pkg::READ_UNMAPPED;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode and current cap outputs
   // ----------------------------------------------------------------
   // Core mode is forced to sleep while the level sits under the ramp floor
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coreOpSelect <= bct_pkg::OP_SLEEP;
         coreCurrentCap <= 2'h0;
         processorOpSelect <= bct_pkg::OP_SLEEP;
         processorCurrentCap <= 2'h0;
         memoryOpSelect <= bct_pkg::OP_SLEEP;
         memoryCurrentCap <= 2'h0;
         peripheralOpSelect <= bct_pkg::OP_SLEEP;
         peripheralCurrentCap <= 2'h0;
      end else begin
         if (ramp.level < bct_pkg::FLOOR_LEVEL) begin
            coreOpSelect <= bct_pkg::OP_SLEEP;
         end else begin
            coreOpSelect <= modeLimitFirst[bct_pkg::OP_SELECT_LO_POS +: bct_pkg::FIELD2_W];
         end
         coreCurrentCap <= modeLimitFirst[bct_pkg::CURRENT_CAP_LO_POS +: bct_pkg::FIELD2_W];
         processorOpSelect <= modeLimitFirst[bct_pkg::OP_SELECT_HI_POS +: bct_pkg::FIELD2_W];
         processorCurrentCap <= modeLimitFirst[bct_pkg::CURRENT_CAP_HI_POS +: bct_pkg::FIELD2_W];
         memoryOpSelect <= modeLimitSecond[bct_pkg::OP_SELECT_LO_POS +: bct_pkg::FIELD2_W];
         memoryCurrentCap <= modeLimitSecond[bct_pkg::CURRENT_CAP_LO_POS +: bct_pkg::FIELD2_W];
         peripheralOpSelect <= modeLimitSecond[bct_pkg::OP_SELECT_HI_POS +: bct_pkg::FIELD2_W];
         peripheralCurrentCap <= modeLimitSecond[bct_pkg::CURRENT_CAP_HI_POS +: bct_pkg::FIELD2_W];
      end
   end

   // ----------------------------------------------------------------
   // Core apply control
   // ----------------------------------------------------------------
   // Ramp mode applies on the trigger; preset mode waits for the slot
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rampStart <= 1'b0;
         rampTarget <= 8'h00;
      end else begin
         rampStart <= 1'b0;
         if (coreApplyNow) begin
            rampStart <= 1'b1;
            rampTarget <= {coreVoltageCode, 2'b00};
         end
      end
   end

   // Enable follows the bit at once unless held back as a preset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coreTurnOnApplied <= 1'b0;
      end else if (resetPowerState) begin
         coreTurnOnApplied <= 1'b0;
      end else if (!corePresetSelect) begin
         coreTurnOnApplied <= coreTurnOn;
      end else if (coreSequencerSlot) begin
         coreTurnOnApplied <= coreTurnOn;
      end
   end

   // ----------------------------------------------------------------
   // Converter run outputs
   // ----------------------------------------------------------------
   // The halt is a level so converters outside this bank can gate on it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         coreStepDownOn <= 1'b0;
         allStepDownHalt <= 1'b0;
         coreVoltageLevel <= 8'h00;
         coreSlewing <= 1'b0;
      end else begin
         coreStepDownOn <= coreTurnOnApplied && !resetPowerState;
         allStepDownHalt <= resetPowerState;
         coreVoltageLevel <= ramp.level;
         coreSlewing <= ramp.slewing;
      end
   end

   assign ramp.start = rampStart;
   assign ramp.target = rampTarget;

   bct_ramp_engine #(
      .STEP_CYCLES(STEP_CYCLES)
   ) u_ramp (
      .clk(clk),
      .rst_n(rst_n),
      .ramp(ramp)
   );

endmodule

// ==== sim/bct_buck_regs_sva.sv ====
// Concurrent checks on the step-down control register bank ports.
// Assumes a bind to bct_buck_regs, one clock and an active-low reset.
`timescale 1ns/1ns
module bct_buck_regs_sva #(
   parameter int STEP_CYCLES = bct_pkg::STEP_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] regAddr,
   input wire logic regWrite,
   input wire logic [7:0] regWriteData,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic regReadValid,
   input wire logic resetPowerState,
   input wire logic [1:0] coreOpSelect,
   input wire logic [1:0] coreCurrentCap,
   input wire logic [1:0] processorOpSelect,
   input wire logic [1:0] processorCurrentCap,
   input wire logic [7:0] coreVoltageLevel,
   input wire logic coreStepDownOn,
   input wire logic allStepDownHalt
);
   // ------------------------------------------------------------
   // Sequences and properties
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence wrFirst;
      regWrite && regAddr == 8'h2C ##1 !(regWrite && regAddr == 8'h2C);
   endsequence
   sequence wrRdSecond;
      regWrite && regAddr == 8'h2D ##1 regRead && !regWrite && regAddr == 8'h2D;
   endsequence
   // Reset power state must stay low until the registered run output is seen
   sequence onReq;
      regWrite && regAddr == 8'h2E && regWriteData[7:6] == 2'b01 && !resetPowerState
         ##1 !resetPowerState [*2];
   endsequence
   read_valid_a: assert property (regRead |=> regReadValid) else $error("no read valid");
   unmapped_read_a: assert property (
      regRead && !(regAddr inside {[8'h2C:8'h2E]}) |=> regReadData == 8'h00)
      else $error("unmapped read not zero");
   read_back_a: assert property (
      wrRdSecond |=> regReadData == $past(regWriteData, 2))
      else $error("read back differs");
   first_fields_a: assert property (
      wrFirst |=> {processorCurrentCap, processorOpSelect, coreCurrentCap}
      == $past(regWriteData[7:2], 2)) else $error("fields wrong");
   core_enable_a: assert property (onReq |=> coreStepDownOn) else $error("not on");
   halt_follow_a: assert property (resetPowerState |=> allStepDownHalt)
      else $error("halt not shown");
   halt_off_a: assert property (resetPowerState |=> !coreStepDownOn)
      else $error("still on");
   floor_sleep_a: assert property (
      (coreVoltageLevel < 8'h24) [*2] |-> coreOpSelect == 2'h0)
      else $error("not sleep below floor");
   step_size_a: assert property (
      ($changed(coreVoltageLevel) && coreVoltageLevel >= 8'h24
      && $past(coreVoltageLevel) >= 8'h24) |-> (coreVoltageLevel == $past(coreVoltageLevel)
      + 8'h01 || coreVoltageLevel + 8'h01 == $past(coreVoltageLevel)))
      else $error("level jumped");
   step_space_a: assert property (
      ($changed(coreVoltageLevel) && coreVoltageLevel > 8'h24 && STEP_CYCLES > 1)
      |=> $stable(coreVoltageLevel)) else $error("steps too close");
endmodule

// ==== sim/test_bct_buck_regs.sv ====
// Self-checking bench for the step-down control register bank.
// Assumes the bank and its ramp engine are compiled with the package.
`timescale 1ns/1ns
module test_bct_buck_regs;
   logic clk, rst_n, regWrite, regRead, coreRampTrigger, coreSequencerSlot, resetPowerState;
   logic [7:0] regAddr, regWriteData, regReadData, coreVoltageLevel;
   logic regReadValid, coreSlewing, coreStepDownOn, allStepDownHalt;
   logic [1:0] coreOpSelect, coreCurrentCap, processorOpSelect, processorCurrentCap;
   logic [1:0] memoryOpSelect, memoryCurrentCap, peripheralOpSelect, peripheralCurrentCap;
   logic [7:0] pats [4] = '{8'h00, 8'h55, 8'hAA, 8'hFF};
   int nErrors, numChecks, cycles;

   // Short step time keeps every ramp under a hundred cycles
   bct_buck_regs #(.STEP_CYCLES(2)) u_dut (.clk, .rst_n, .regAddr, .regWrite, .regWriteData,
      .regRead, .regReadData, .regReadValid, .coreRampTrigger, .coreSequencerSlot,
      .resetPowerState, .coreOpSelect, .coreCurrentCap, .processorOpSelect,
      .processorCurrentCap, .memoryOpSelect, .memoryCurrentCap, .peripheralOpSelect,
      .peripheralCurrentCap, .coreVoltageLevel, .coreSlewing, .coreStepDownOn,
      .allStepDownHalt);

   // ------------------------------------------------------------
   // Clock, timeout and access tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         nErrors++;
         report_and_stop();
      end
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Strobes stay up until the next task lowers them, so no signal is set twice in one step
   task wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      regRead = 1'b0;
      @(negedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [7:0] e);
      regAddr = a;
      regRead = 1'b1;
      regWrite = 1'b0;
      @(negedge clk);
      chk(regReadData, e);
      chk({7'h00, regReadValid}, 8'h01);
   endtask
   task idle(input int n);
      regWrite = 1'b0;
      regRead = 1'b0;
      repeat (n) @(negedge clk);
   endtask
   task pulse(input logic slot);
      idle(0);
      coreRampTrigger = !slot;
      coreSequencerSlot = slot;
      @(negedge clk);
      coreRampTrigger = 1'b0;
      coreSequencerSlot = 1'b0;
   endtask
   task waitLvl(input logic [7:0] e);
      int k;
      k = 0;
      while (coreVoltageLevel !== e && k < 1000) begin
         idle(1);
         k++;
      end
      chk(coreVoltageLevel, e);
   endtask
   task done(input string s);
      $display("test %s done", s);
   endtask
   task report_and_stop();
      $display("checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------
   initial begin
      {rst_n, regWrite, regRead, coreRampTrigger, coreSequencerSlot, resetPowerState} = '0;
      regAddr = 8'h00;
      regWriteData = 8'h00;
      cycles = 0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      for (int a = 'h2B; a < 'h30; a++) rd(8'(a), 8'h00);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         wr(8'h2C, pats[i]);
         wr(8'h2D, ~pats[i]);
         rd(8'h2D, ~pats[i]);
         rd(8'h2C, pats[i]);
         chk({processorCurrentCap, processorOpSelect,
            coreCurrentCap, coreOpSelect}, {pats[i][7:2], 2'b00});
         chk({peripheralCurrentCap, peripheralOpSelect,
            memoryCurrentCap, memoryOpSelect}, ~pats[i]);
      end
      wr(8'h2F, 8'hFF);
      rd(8'h2F, 8'h00);
      rd(8'h2C, 8'hFF);
      done("fields");
      wr(8'h2C, 8'h01);
      wr(8'h2E, 8'h4A);
      idle(3);
      chk({7'h00, coreStepDownOn}, 8'h01);
      pulse(1'b0);
      idle(2);
      chk({7'h00, coreSlewing}, 8'h01);
      waitLvl(8'h28);
      idle(3);
      chk({7'h00, coreSlewing}, 8'h00);
      chk({6'h00, coreOpSelect}, 8'h01);
      done("ramp");
      wr(8'h2E, 8'hCC);
      pulse(1'b0);
      idle(20);
      chk(coreVoltageLevel, 8'h28);
      chk({7'h00, coreSlewing}, 8'h00);
      pulse(1'b1);
      waitLvl(8'h30);
      rd(8'h2E, 8'hCC);
      done("preset");
      wr(8'h2E, 8'h42);
      pulse(1'b0);
      waitLvl(8'h08);
      chk({6'h00, coreOpSelect}, 8'h00);
      done("floor");
      resetPowerState = 1'b1;
      idle(2);
      chk({6'h00, allStepDownHalt, coreStepDownOn}, 8'h02);
      resetPowerState = 1'b0;
      done("halt");
      report_and_stop();
   end
endmodule

bind bct_buck_regs bct_buck_regs_sva #(.STEP_CYCLES(STEP_CYCLES)) u_sva (.clk, .rst_n,
   .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .regReadValid,
   .resetPowerState, .coreOpSelect, .coreCurrentCap, .processorOpSelect,
   .processorCurrentCap, .coreVoltageLevel, .coreStepDownOn, .allStepDownHalt);
